/* File: odufc_pkg.sv */
// package: constants, codes and helpers of the odu overhead field codec
// assumes: ODU bit 1 is the msb of each byte carried on the link
package odufc_pkg;
   // ************************************************************
   // register map (byte addresses, avalon-mm, one word each)
   // ************************************************************
   localparam logic [10:0] ADDR_CTRL     = 11'h000; // psi entry mode
   localparam logic [10:0] ADDR_PM       = 11'h004; // path monitoring byte 3
   localparam logic [10:0] ADDR_TCM      = 11'h008; // tandem connection byte 3
   localparam logic [10:0] ADDR_APS      = 11'h00C; // four aps/pcc bytes
   localparam logic [10:0] ADDR_PSI      = 11'h010; // raw type and selection
   localparam logic [10:0] ADDR_FIF      = 11'h014; // forward/backward fault bytes
   localparam logic [10:0] ADDR_STATUS   = 11'h018; // multiframe and signal fail
   localparam logic [10:0] ADDR_IRQ_STAT = 11'h01C; // sticky events, read only
   localparam logic [10:0] ADDR_IRQ_CLR  = 11'h020; // write one to clear
   localparam logic [10:0] ADDR_IRQ_EN   = 11'h024; // event enables
   localparam logic [1:0]  PAGE_TTI      = 2'h1;    // 0x200..0x3FC trace bytes
   localparam logic [1:0]  PAGE_FTFL     = 2'h2;    // 0x400..0x7FC fault message
   // ************************************************************
   // field positions inside an overhead byte and in the registers
   // ************************************************************
   localparam int BEI_MSB  = 7; // bits 1-4
   localparam int BEI_LSB  = 4;
   localparam int BDI_POS  = 3; // bit 5
   localparam int STAT_MSB = 2; // bits 6-8
   localparam int PSI_SEL_LSB = 8;  // selection field in psi register
   localparam int BIAE_POS    = 4;  // alarm flag in tcm register
   localparam int STAT_REG_LSB = 5; // status field in pm/tcm register
   // ************************************************************
   // codes
   // ************************************************************
   localparam logic [3:0] BEI_MAX    = 4'h8; // largest violation count
   localparam logic [3:0] BEI_BIAE   = 4'hB; // only alignment error code
   localparam logic [2:0] TST_NO_SRC = 3'h0, TST_OK = 3'h1, TST_IAE = 3'h2;
   localparam logic [2:0] ST_LCK = 3'h5, ST_OCI = 3'h6, ST_AIS = 3'h7;
   localparam logic [2:0] PST_NORMAL = 3'h1;
   localparam logic [7:0] FIF_NONE = 8'h00, FIF_SF = 8'h01, FIF_SD = 8'h02;
   localparam logic [7:0] PT_CLIENT_LO = 8'h01, PT_CLIENT_HI = 8'h1C;
   localparam logic [7:0] PT_MUX_AMP = 8'h20, PT_MUX_GMP = 8'h21;
   localparam logic [7:0] PT_NA1 = 8'h55, PT_NA2 = 8'h66, PT_NA3 = 8'hFF;
   localparam logic [7:0] PT_PROP = 8'h80, PT_NULL = 8'hFD, PT_PRBS = 8'hFE;
   localparam logic [7:0] FTFL_BWD_IDX = 8'h80; // first byte of backward half
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] PM_RST   = 8'h20; // status normal, no errors
   localparam logic [7:0] TCM_RST  = 8'h20; // in use without alignment error
   localparam logic [7:0] PSI_RST  = 8'h02; // asynchronous cbr
   localparam logic [2:0] IRQ_WRAP = 3'h1, IRQ_SF_ON = 3'h2, IRQ_SF_OFF = 3'h4;
   typedef enum logic [2:0] {
      PSI_CLIENT, PSI_MUX_AMP, PSI_MUX_GMP, PSI_PROPRIETARY,
      PSI_NULL_TEST, PSI_PRBS_TEST, PSI_NOT_AVAIL, PSI_OTHER
   } odufc_psi_class_t;
   // fault byte classes seen by a sink
   typedef enum logic [1:0] {FLT_NONE, FLT_SF, FLT_SD, FLT_RSVD} odufc_fault_t;

   // violation count from a bits 1-4 code; codes above eight count zero
   function automatic logic [3:0] odufc_bei_count(input logic [3:0] code);
      odufc_bei_count = (code > BEI_MAX) ? 4'h0 : code;
   endfunction

   // payload type code from a selection index
   function automatic logic [7:0] odufc_pt_from_sel(input logic [5:0] sel);
      if (sel >= 6'h01 && sel <= 6'h1C) odufc_pt_from_sel = {2'b00, sel};
      else if (sel == 6'h1D) odufc_pt_from_sel = PT_MUX_AMP;
      else if (sel == 6'h1E) odufc_pt_from_sel = PT_MUX_GMP;
      else if (sel == 6'h1F) odufc_pt_from_sel = PT_PROP;
      else if (sel == 6'h20) odufc_pt_from_sel = PT_NULL;
      else if (sel == 6'h21) odufc_pt_from_sel = PT_PRBS;
      else odufc_pt_from_sel = PT_NA3;
   endfunction
endpackage

/* File: odufc_link_if.sv */
// interface: per-frame overhead bytes from the device end to the far end
// assumes: both ends share one clock; all fields change only with frame
interface odufc_link_if;
   logic        frame;   // one-cycle pulse, fields below valid with it
   logic [7:0]  mfas;    // multiframe number of this frame
   logic [7:0]  pm3;     // path monitoring third byte
   logic [7:0]  tcm3;    // tandem connection third byte
   logic [7:0]  pm_tti;  // path trace byte of this frame
   logic [7:0]  tcm_tti; // tandem trace byte of this frame
   logic [31:0] aps;     // aps/pcc bytes, first byte in [31:24]
   logic [7:0]  psi0;    // payload type byte
   logic [7:0]  ftfl;    // fault message byte of this frame
   modport dev (output frame, mfas, pm3, tcm3, pm_tti, tcm_tti, aps, psi0, ftfl);
   modport far (input  frame, mfas, pm3, tcm3, pm_tti, tcm_tti, aps, psi0, ftfl);
endinterface

/* File: odufc_dev_end.sv */
// device end: holds the overhead fields and inserts them in every frame
// assumes: frame tick and signal fail come from framer logic on CLOCK_I

// Overview of operation
// - bits 1-4 carry violation count 0..8
// - only code 1011 means alignment error
// - bit 5 follows signal fail
// - tandem status codes in bits 6-8
// - fault message has forward, backward 128-byte halves
// - fault byte: none, fail, degrade, reserved
// - operator id: country code plus carrier code
// - path bits 1-4 count, no alignment code
// - 64-byte trace, one byte per frame
// - path status codes in bits 6-8
// - aps first byte: request, protection type
// - defined protection request codes
// - payload type raw or selected
// - codes 01-1C are client mappings
// - codes 20 and 21 are multiplex structures
// - test, proprietary and unavailable type codes
// - multiframe count 0..255, wrapping
module odufc_dev_end import odufc_pkg::*; (
   // clock and reset
   input  wire logic        CLOCK_I,
   input  wire logic        SRST_I,
   // framer side
   input  wire logic        FRAME_TICK_I,
   input  wire logic        SIGNAL_FAIL_I,
   // avalon-mm slave
   input  wire logic [10:0] AVS_ADDRESS_I,
   input  wire logic        AVS_READ_I,
   input  wire logic        AVS_WRITE_I,
   input  wire logic [31:0] AVS_WRITEDATA_I,
   output logic      [31:0] AVS_READDATA_O,
   output logic             AVS_WAITREQUEST_O,
   // interrupt
   output logic             IRQ_O,
   // link
   odufc_link_if.dev        link
);
   // ************************************************************
   // storage
   // ************************************************************
   logic [7:0]  tti_mem [0:127]; // path trace 0..63, tandem 64..127
   logic [7:0]  ftfl_mem [0:255]; // fault message bytes
   logic        psi_mode_q;      // 1: payload type from selection
   logic [7:0]  pm_q;            // count [3:0], status [7:5]
   logic [7:0]  tcm_q;           // count [3:0], alarm [4], status [7:5]
   logic [31:0] aps_q;           // aps/pcc bytes
   logic [7:0]  psi_raw_q;       // raw payload type
   logic [5:0]  psi_sel_q;       // payload type selection
   logic [15:0] fif_q;           // forward [7:0], backward [15:8]
   logic [7:0]  mfas_q;          // multiframe counter
   logic        sf_q;            // signal fail, last cycle
   logic [2:0]  irq_st_q;        // sticky events
   logic [2:0]  irq_en_q;        // event enables
   logic        wait_q;          // waitrequest
   logic [31:0] rdata_q;         // read data
   logic        irq_q;           // interrupt level
   logic        wr_go;           // write accepted this cycle
   logic        rd_go;           // read data taken in the wait cycle
   logic [2:0]  ev;              // events this cycle
   logic [1:0]  page;            // address page
   logic [31:0] rd_mux;          // read data source
   logic [3:0]  pm_bei;          // encoded path count
   logic [3:0]  tcm_bei;         // encoded tandem count
   logic [7:0]  ftfl_byte;       // fault byte for this frame
   logic [7:0]  psi0;            // payload type for this frame

   assign page  = AVS_ADDRESS_I[10:9];
   assign wr_go = AVS_WRITE_I && !wait_q;
   assign rd_go = AVS_READ_I && wait_q;

   // ************************************************************
   // avalon handshake: one wait cycle, then the answer
   // ************************************************************
   // drop waitrequest for one cycle per request
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         wait_q <= 1'b1;
      end else if ((AVS_READ_I || AVS_WRITE_I) && wait_q) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= 1'b1;
      end
   end

   // read data mux; unmapped addresses read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (page == PAGE_TTI) begin
         rd_mux = {24'h00_0000, tti_mem[AVS_ADDRESS_I[8:2]]};
      end else if (page >= PAGE_FTFL) begin
         rd_mux = {24'h00_0000, ftfl_mem[AVS_ADDRESS_I[9:2]]};
      end else begin
         case (AVS_ADDRESS_I)
            ADDR_CTRL:     rd_mux = {31'h0, psi_mode_q};
            ADDR_PM:       rd_mux = {24'h00_0000, pm_q};
            ADDR_TCM:      rd_mux = {24'h00_0000, tcm_q};
            ADDR_APS:      rd_mux = aps_q;
            ADDR_PSI:      rd_mux = {18'h0, psi_sel_q, psi_raw_q};
            ADDR_FIF:      rd_mux = {16'h0000, fif_q};
            ADDR_STATUS:   rd_mux = {23'h0, sf_q, mfas_q};
            ADDR_IRQ_STAT: rd_mux = {29'h0, irq_st_q};
            ADDR_IRQ_EN:   rd_mux = {29'h0, irq_en_q};
            default:       rd_mux = 32'h0000_0000; // clear reg and holes
         endcase
      end
   end

   // capture read data with the answer
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_go) begin
         rdata_q <= rd_mux;
      end
   end

   // ************************************************************
   // configuration registers
   // ************************************************************
   // held until software writes again
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         psi_mode_q <= 1'b0;
         pm_q       <= PM_RST;
         tcm_q      <= TCM_RST;
         aps_q      <= 32'h0000_0000;
         psi_raw_q  <= PSI_RST;
         psi_sel_q  <= 6'h02;
         fif_q      <= {FIF_NONE, FIF_NONE};
         irq_en_q   <= 3'h0;
      end else if (wr_go) begin
         case (AVS_ADDRESS_I)
            ADDR_CTRL:   psi_mode_q <= AVS_WRITEDATA_I[0];
            ADDR_PM:     pm_q       <= AVS_WRITEDATA_I[7:0];
            ADDR_TCM:    tcm_q      <= AVS_WRITEDATA_I[7:0];
            ADDR_APS:    aps_q      <= AVS_WRITEDATA_I;
            ADDR_PSI: begin
               psi_raw_q <= AVS_WRITEDATA_I[7:0];
               psi_sel_q <= AVS_WRITEDATA_I[PSI_SEL_LSB+5:PSI_SEL_LSB];
            end
            ADDR_FIF:    fif_q      <= AVS_WRITEDATA_I[15:0];
            ADDR_IRQ_EN: irq_en_q   <= AVS_WRITEDATA_I[2:0];
            default: begin
            end
         endcase
      end
   end

   // trace and fault message memories, one byte per word
   always_ff @(posedge CLOCK_I) begin
      if (wr_go && page == PAGE_TTI) begin
         tti_mem[AVS_ADDRESS_I[8:2]] <= AVS_WRITEDATA_I[7:0];
      end
      if (wr_go && page >= PAGE_FTFL) begin
         ftfl_mem[AVS_ADDRESS_I[9:2]] <= AVS_WRITEDATA_I[7:0];
      end
   end

   // ************************************************************
   // interrupts
   // ************************************************************
   assign ev[0] = FRAME_TICK_I && (mfas_q == 8'hFF);
   assign ev[1] = SIGNAL_FAIL_I && !sf_q;
   assign ev[2] = !SIGNAL_FAIL_I && sf_q;

   // sticky events; a new event wins over its clear
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         irq_st_q <= 3'h0;
         sf_q     <= 1'b0;
         irq_q    <= 1'b0;
      end else begin
         sf_q <= SIGNAL_FAIL_I;
         if (wr_go && AVS_ADDRESS_I == ADDR_IRQ_CLR) begin
            irq_st_q <= (irq_st_q & ~AVS_WRITEDATA_I[2:0]) | ev;
         end else begin
            irq_st_q <= irq_st_q | ev;
         end
         irq_q <= |(irq_st_q & irq_en_q);
      end
   end

   // ************************************************************
   // field encoding
   // ************************************************************
   // counts above eight are sent as eight
   assign pm_bei  = (pm_q[3:0] > BEI_MAX) ? BEI_MAX : pm_q[3:0];
   // alarm flag replaces the count with the single alarm code
   assign tcm_bei = tcm_q[BIAE_POS] ? BEI_BIAE :
                    ((tcm_q[3:0] > BEI_MAX) ? BEI_MAX : tcm_q[3:0]);
   // payload type: raw byte or chosen defined type
   assign psi0 = psi_mode_q ? odufc_pt_from_sel(psi_sel_q) : psi_raw_q;
   // fault bytes at the head of each half come from the fault register
   always_comb begin
      ftfl_byte = ftfl_mem[mfas_q];
      if (mfas_q == 8'h00) begin
         ftfl_byte = fif_q[7:0];
      end else if (mfas_q == FTFL_BWD_IDX) begin
         ftfl_byte = fif_q[15:8];
      end
   end

   // ************************************************************
   // multiframe counter and frame insertion
   // ************************************************************
   // count frames, wrap after 255
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         mfas_q <= 8'h00;
      end else if (FRAME_TICK_I) begin
         mfas_q <= mfas_q + 8'h01;
      end
   end

   // send every field with each frame
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         link.frame   <= 1'b0;
         link.mfas    <= 8'h00;
         link.pm3     <= 8'h00;
         link.tcm3    <= 8'h00;
         link.pm_tti  <= 8'h00;
         link.tcm_tti <= 8'h00;
         link.aps     <= 32'h0000_0000;
         link.psi0    <= 8'h00;
         link.ftfl    <= 8'h00;
      end else begin
         link.frame <= FRAME_TICK_I;
         if (FRAME_TICK_I) begin
            link.mfas    <= mfas_q;
            link.pm3     <= {pm_bei, SIGNAL_FAIL_I, pm_q[7:STAT_REG_LSB]};
            link.tcm3    <= {tcm_bei, SIGNAL_FAIL_I, tcm_q[7:STAT_REG_LSB]};
            link.pm_tti  <= tti_mem[{1'b0, mfas_q[5:0]}];
            link.tcm_tti <= tti_mem[{1'b1, mfas_q[5:0]}];
            link.aps     <= aps_q;
            link.psi0    <= psi0;
            link.ftfl    <= ftfl_byte;
         end
      end
   end

   assign AVS_WAITREQUEST_O = wait_q;
   assign AVS_READDATA_O    = rdata_q;
   assign IRQ_O             = irq_q;
endmodule // odufc_dev_end

/* File: odufc_far_end.sv */
// far end: decodes the overhead fields received with each frame
// assumes: link driven by logic on the same clock, no synchroniser needed
module odufc_far_end import odufc_pkg::*; (
   // clock and reset
   input  wire logic        CLOCK_I,
   input  wire logic        SRST_I,
   // link
   odufc_link_if.far        link,
   // decoded path monitoring
   output logic [3:0]       PM_BEI_COUNT_O,
   output logic             PM_BDI_O,
   output logic [2:0]       PM_STAT_O,
   output logic             PM_STAT_RSVD_O,
   // decoded tandem connection
   output logic [3:0]       TCM_BEI_COUNT_O,
   output logic             TCM_BIAE_O,
   output logic             TCM_BDI_O,
   output logic [2:0]       TCM_STAT_O,
   output logic             TCM_STAT_RSVD_O,
   // protection and payload
   output logic [3:0]       APS_REQ_O,
   output logic [3:0]       APS_PTYPE_O,
   output logic             APS_REQ_RSVD_O,
   output logic [7:0]       PSI_TYPE_O,
   output odufc_psi_class_t PSI_CLASS_O,
   // fault message
   output odufc_fault_t     FTFL_FWD_O,
   output odufc_fault_t     FTFL_BWD_O,
   // frame and captured bytes
   output logic             FRAME_O,
   output logic [7:0]       MFAS_O,
   input  wire logic [6:0]  TTI_RD_ADDR_I,
   output logic [7:0]       TTI_RD_DATA_O,
   input  wire logic [7:0]  FTFL_RD_ADDR_I,
   output logic [7:0]       FTFL_RD_DATA_O
);
   logic [7:0] tti_mem [0:127];  // received trace bytes
   logic [7:0] ftfl_mem [0:255]; // received fault message bytes
   logic [3:0] req;              // received request code
   logic       req_ok;           // request code is defined

   assign req = link.aps[31:28];
   // defined requests
   always_comb begin
      case (req)
         4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE, 4'hF: req_ok = 1'b1;
         default: req_ok = 1'b0;
      endcase
   end

   // fault byte class
   function automatic odufc_fault_t fault_of(input logic [7:0] b);
      if (b == FIF_NONE) fault_of = FLT_NONE;
      else if (b == FIF_SF) fault_of = FLT_SF;
      else if (b == FIF_SD) fault_of = FLT_SD;
      else fault_of = FLT_RSVD;
   endfunction

   // payload type class
   function automatic odufc_psi_class_t class_of(input logic [7:0] b);
      if (b >= PT_CLIENT_LO && b <= PT_CLIENT_HI) class_of = PSI_CLIENT;
      else if (b == PT_MUX_AMP) class_of = PSI_MUX_AMP;
      else if (b == PT_MUX_GMP) class_of = PSI_MUX_GMP;
      else if (b == PT_PROP) class_of = PSI_PROPRIETARY;
      else if (b == PT_NULL) class_of = PSI_NULL_TEST;
      else if (b == PT_PRBS) class_of = PSI_PRBS_TEST;
      else if (b == PT_NA1 || b == PT_NA2 || b == PT_NA3) class_of = PSI_NOT_AVAIL;
      else class_of = PSI_OTHER;
   endfunction

   // ************************************************************
   // decode on each frame
   // ************************************************************
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         PM_BEI_COUNT_O  <= 4'h0;
         PM_BDI_O        <= 1'b0;
         PM_STAT_O       <= 3'h0;
         PM_STAT_RSVD_O  <= 1'b0;
         TCM_BEI_COUNT_O <= 4'h0;
         TCM_BIAE_O      <= 1'b0;
         TCM_BDI_O       <= 1'b0;
         TCM_STAT_O      <= 3'h0;
         TCM_STAT_RSVD_O <= 1'b0;
         APS_REQ_O       <= 4'h0;
         APS_PTYPE_O     <= 4'h0;
         APS_REQ_RSVD_O  <= 1'b0;
         PSI_TYPE_O      <= 8'h00;
         PSI_CLASS_O     <= PSI_OTHER;
         FTFL_FWD_O      <= FLT_NONE;
         FTFL_BWD_O      <= FLT_NONE;
         FRAME_O         <= 1'b0;
         MFAS_O          <= 8'h00;
      end else begin
         FRAME_O <= link.frame;
         if (link.frame) begin
            MFAS_O          <= link.mfas;
            PM_BEI_COUNT_O  <= odufc_bei_count(link.pm3[BEI_MSB:BEI_LSB]);
            PM_BDI_O        <= link.pm3[BDI_POS];
            PM_STAT_O       <= link.pm3[STAT_MSB:0];
            PM_STAT_RSVD_O  <= !(link.pm3[STAT_MSB:0] == PST_NORMAL ||
                                 link.pm3[STAT_MSB:0] >= ST_LCK);
            TCM_BEI_COUNT_O <= odufc_bei_count(link.tcm3[BEI_MSB:BEI_LSB]);
            TCM_BIAE_O      <= link.tcm3[BEI_MSB:BEI_LSB] == BEI_BIAE;
            TCM_BDI_O       <= link.tcm3[BDI_POS];
            TCM_STAT_O      <= link.tcm3[STAT_MSB:0];
            TCM_STAT_RSVD_O <= link.tcm3[STAT_MSB:0] == 3'h3 ||
                               link.tcm3[STAT_MSB:0] == 3'h4;
            APS_REQ_O       <= req;
            APS_PTYPE_O     <= link.aps[27:24];
            APS_REQ_RSVD_O  <= !req_ok;
            PSI_TYPE_O      <= link.psi0;
            PSI_CLASS_O     <= class_of(link.psi0);
            if (link.mfas == 8'h00) FTFL_FWD_O <= fault_of(link.ftfl);
            if (link.mfas == FTFL_BWD_IDX) FTFL_BWD_O <= fault_of(link.ftfl);
         end
      end
   end

   // ************************************************************
   // trace and fault message capture, aligned to the multiframe
   // ************************************************************
   always_ff @(posedge CLOCK_I) begin
      if (link.frame) begin
         tti_mem[{1'b0, link.mfas[5:0]}] <= link.pm_tti;
         tti_mem[{1'b1, link.mfas[5:0]}] <= link.tcm_tti;
         ftfl_mem[link.mfas] <= link.ftfl;
      end
      TTI_RD_DATA_O  <= tti_mem[TTI_RD_ADDR_I];
      FTFL_RD_DATA_O <= ftfl_mem[FTFL_RD_ADDR_I];
   end
endmodule // odufc_far_end

/* File: odufc_assertions.sv */
// checker: relations on the link between the two codec ends
// assumes: one clock domain, synchronous active-high reset
module odufc_assertions (
   // clock and reset
   input wire logic        CLOCK_I,
   input wire logic        SRST_I,
   // link fields
   input wire logic        frame,
   input wire logic [7:0]  mfas,
   input wire logic [7:0]  pm3,
   input wire logic [7:0]  tcm3,
   input wire logic [7:0]  pm_tti,
   input wire logic [7:0]  tcm_tti,
   input wire logic [31:0] aps,
   input wire logic [7:0]  psi0,
   input wire logic [7:0]  ftfl
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       seen_q; // a frame went out since reset
   logic [7:0] last_q; // multiframe number of that frame
   default clocking dcb @(posedge CLOCK_I); endclocking
   default disable iff (SRST_I);
   // remember the last multiframe number sent
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         seen_q <= 1'b0;
         last_q <= 8'h00;
      end else if (frame) begin
         seen_q <= 1'b1;
         last_q <= mfas;
      end
   end
   AST_PM_COUNT: assert property (frame |-> pm3[7:4] <= 4'h8)
      else $error("path count code above eight");
   AST_TCM_COUNT: assert property (frame |-> (tcm3[7:4] <= 4'h8 || tcm3[7:4] == 4'hB))
      else $error("tandem count code out of range");
   AST_BDI_SAME: assert property (frame |-> pm3[3] == tcm3[3])
      else $error("defect bits differ");
   AST_MFAS_FIRST: assert property (frame && !seen_q |-> mfas == 8'h00)
      else $error("first multiframe number not zero");
   AST_MFAS_STEP: assert property (frame && seen_q |-> mfas == last_q + 8'h01)
      else $error("multiframe number did not step");
   AST_HOLD_OH3: assert property (!frame |-> $stable({pm3, tcm3}))
      else $error("third bytes moved between frames");
   AST_HOLD_APS: assert property (!frame |-> $stable({aps, psi0}))
      else $error("aps or payload type moved between frames");
   AST_HOLD_TRACE: assert property (!frame |-> $stable({pm_tti, tcm_tti, ftfl, mfas}))
      else $error("trace bytes moved between frames");
endmodule // odufc_assertions

/* File: test_odu_overhead_field_codec.sv */
// testbench: both codec ends joined by the link, software side over avalon-mm
// assumes: far outputs settle two cycles after each frame tick
module test_odu_overhead_field_codec import odufc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock = 1'b0, srst = 1'b1, tick = 1'b0, sf = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [10:0] addr = 11'h000;
   logic [31:0] wdata = 32'h0, rdata, q, a;
   logic        waitreq, irq, pm_bdi, pm_rsv, tcm_biae, tcm_bdi, tcm_rsv, req_rsv;
   logic [7:0]  ftfl_a = 8'h00, tti_d, ftfl_d, pt, mfas_o, p;
   logic [6:0]  tti_a = 7'h00;
   logic [3:0]  pm_cnt, tcm_cnt, req, ptype, c;
   logic [2:0]  pm_st, tcm_st, s;
   odufc_psi_class_t cls_o;
   odufc_fault_t     fwd_o, bwd_o;
   int          miscompares = 0, check_count = 0;
   odufc_link_if link ();
   odufc_dev_end odufc_dev_end_inst (.CLOCK_I(clock), .SRST_I(srst), .FRAME_TICK_I(tick),
      .SIGNAL_FAIL_I(sf), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
      .IRQ_O(irq), .link(link.dev));
   odufc_far_end odufc_far_end_inst (.CLOCK_I(clock), .SRST_I(srst), .link(link.far),
      .PM_BEI_COUNT_O(pm_cnt), .PM_BDI_O(pm_bdi), .PM_STAT_O(pm_st), .PM_STAT_RSVD_O(pm_rsv),
      .TCM_BEI_COUNT_O(tcm_cnt), .TCM_BIAE_O(tcm_biae), .TCM_BDI_O(tcm_bdi),
      .TCM_STAT_O(tcm_st), .TCM_STAT_RSVD_O(tcm_rsv), .APS_REQ_O(req), .APS_PTYPE_O(ptype),
      .APS_REQ_RSVD_O(req_rsv), .PSI_TYPE_O(pt), .PSI_CLASS_O(cls_o), .FTFL_FWD_O(fwd_o),
      .FTFL_BWD_O(bwd_o), .FRAME_O(), .MFAS_O(mfas_o), .TTI_RD_ADDR_I(tti_a),
      .TTI_RD_DATA_O(tti_d), .FTFL_RD_ADDR_I(ftfl_a), .FTFL_RD_DATA_O(ftfl_d));
   odufc_assertions odufc_assertions_inst (.CLOCK_I(clock), .SRST_I(srst), .frame(link.frame),
      .mfas(link.mfas), .pm3(link.pm3), .tcm3(link.tcm3), .pm_tti(link.pm_tti),
      .tcm_tti(link.tcm_tti), .aps(link.aps), .psi0(link.psi0), .ftfl(link.ftfl));
   // 100 MHz clock
   always #5 clock = ~clock;
   // compare one result, four-state
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one avalon-mm cycle; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [10:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      {addr, wr, rd, wdata} <= {ad, w, !w, d};
      do begin
         @(posedge clock);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      if (n >= 20) miscompares++;
      q = rdata;
      {wr, rd} <= 2'b00;
   endtask
   // n frame ticks two cycles apart, then let the far end settle
   task automatic frames(input int n);
      repeat (n) begin
         @(posedge clock);
         tick <= 1'b1;
         @(posedge clock);
         tick <= 1'b0;
      end
      repeat (3) @(posedge clock);
   endtask
   // expected payload class of a type byte
   function automatic odufc_psi_class_t exp_cls(input logic [7:0] v);
      if (v >= 8'h01 && v <= 8'h1C) return PSI_CLIENT;
      if (v == 8'h20) return PSI_MUX_AMP;
      if (v == 8'h21) return PSI_MUX_GMP;
      if (v == 8'h80) return PSI_PROPRIETARY;
      if (v == 8'hFD) return PSI_NULL_TEST;
      if (v == 8'hFE) return PSI_PRBS_TEST;
      if (v == 8'h55 || v == 8'h66 || v == 8'hFF) return PSI_NOT_AVAIL;
      return PSI_OTHER;
   endfunction
   task automatic end_of_test();
      if (miscompares == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog
   initial begin
      #100us;
      miscompares++;
      end_of_test();
   end
   initial begin
      static logic [7:0] pts [12] = '{8'h00, 8'h01, 8'h1C, 8'h1D, 8'h20, 8'h21, 8'h55, 8'h66,
                               8'h80, 8'hFD, 8'hFE, 8'hFF};
      void'($urandom(32'h16));
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      bus(1'b0, 11'h004, 32'h0); check(q, 32'h20);
      bus(1'b0, 11'h008, 32'h0); check(q, 32'h20);
      bus(1'b0, 11'h028, 32'h0); check(q, 32'h0);
      // interrupt: raised while masked, then enabled, then cleared
      sf <= 1'b1;
      repeat (3) @(posedge clock);
      bus(1'b0, 11'h01C, 32'h0); check({q[30:0], irq}, 32'h4);
      bus(1'b1, 11'h024, 32'h2);
      repeat (2) @(posedge clock);
      check(irq, 1'b1);
      bus(1'b1, 11'h020, 32'h2);
      repeat (2) @(posedge clock);
      check(irq, 1'b0);
      // every count and request code, random status, each payload corner, one frame each
      for (int i = 0; i < 32; i++) begin
         c = i[3:0];
         s = 3'($urandom);
         p = (i < 12) ? pts[i] : 8'($urandom);
         a = {i[3:0], 28'($urandom)};
         bus(1'b1, 11'h004, {24'h0, s, 1'b0, c});
         bus(1'b1, 11'h008, {24'h0, s, i[4], c});
         bus(1'b1, 11'h00C, a);
         bus(1'b1, 11'h010, {24'h0, p});
         sf <= 1'($urandom);
         frames(1);
         check(pm_cnt, (c > 4'h8) ? 4'h8 : c);
         check({tcm_biae, tcm_cnt}, i[4] ? 5'h10 : {1'b0, (c > 4'h8) ? 4'h8 : c});
         check({pm_bdi, tcm_bdi}, {sf, sf});
         check({pm_st, pm_rsv}, {s, s == 3'h0 || (s >= 3'h2 && s <= 3'h4)});
         check({tcm_st, tcm_rsv}, {s, s == 3'h3 || s == 3'h4});
         check({req, ptype, req_rsv}, {a[31:24], a[28] && c != 4'h1 && c != 4'hF});
         check({pt, 8'(cls_o)}, {p, 8'(exp_cls(p))});
         check(mfas_o, i[7:0]);
      end
      // payload type chosen by selection
      bus(1'b1, 11'h000, 32'h1);
      bus(1'b1, 11'h010, 32'h2100);
      frames(1);
      check(pt, 8'hFE);
      bus(1'b1, 11'h000, 32'h0);
      // trace and fault message bytes over full multiframes
      bus(1'b1, 11'h214, 32'h5A);
      bus(1'b1, 11'h314, 32'hA5);
      bus(1'b1, 11'h61C, 32'h3C);
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, 11'h014, k ? {24'h0, 8'($urandom % 253 + 3)} : 32'h0201);
         frames(256);
         check({fwd_o, bwd_o}, k ? {FLT_RSVD, FLT_NONE} : {FLT_SF, FLT_SD});
      end
      {tti_a, ftfl_a} <= {7'h05, 8'h87};
      repeat (2) @(posedge clock);
      check({tti_d, ftfl_d}, 16'h5A3C);
      tti_a <= 7'h45;
      repeat (2) @(posedge clock);
      check(tti_d, 8'hA5);
      end_of_test();
   end
endmodule // test_odu_overhead_field_codec
